// ===== tb/adcc_far_model.sv
`timescale 1ns/1ps

module adcc_far_model #(
   parameter RES_W  = 10,
   parameter RC_DIV = 8
) (
   input  wire             core_clk,
   input  wire             sys_rst,
   input  wire [RES_W-1:0] ana_level,
   input  wire [RES_W-1:0] trial_code,
   input  wire             timer_count_clear,
   output wire             cmp_above,
   output wire             rc_tick,
   output reg  [15:0]      timer_cnt_ff
);
   localparam [3:0] RC_LAST = 4'(RC_DIV - 1); // last rc phase, one less than the rc period in core cycles
   reg [3:0] rc_cnt_ff;                   // rc oscillator phase

   // analog input held against the dac trial level
   assign cmp_above = (ana_level >= trial_code);
   assign rc_tick   = (rc_cnt_ff == RC_LAST);

   // rc oscillator runs free, not tied to frames
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst || rc_tick) begin
         rc_cnt_ff <= 4'h0;
      end else begin
         rc_cnt_ff <= rc_cnt_ff + 4'h1;
      end
   end

   // timer that the special event restarts
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst || timer_count_clear) begin
         timer_cnt_ff <= 16'h0000;
      end else if (timer_cnt_ff != 16'hffff) begin
         timer_cnt_ff <= timer_cnt_ff + 16'h0001;
      end
   end
endmodule

// ===== tb/adcc_top_monitor.sv
`timescale 1ns/1ps
`include "adcc_consts.vh"

module adcc_top_monitor #(
   parameter RES_W = 10
) (
   input wire             core_clk,
   input wire             sys_rst,
   input wire             clk_en,
   input wire [2:0]       reg_addr,
   input wire [7:0]       reg_wdata,
   input wire             reg_wr,
   input wire             reg_rd,
   input wire [7:0]       reg_rdata,
   input wire [3:0]       compare_unit_mode_field,
   input wire             special_event_trig,
   input wire             rc_tick,
   input wire             cmp_above,
   input wire             timer_count_clear,
   input wire [RES_W-1:0] sar_trial_code,
   input wire             sample_en,
   input wire             conv_busy,
   input wire [3:0]       channel_select,
   input wire [5:0]       pin_reference_cfg,
   input wire             irq,
   input wire             irq_high_prio
);
   localparam int MIN_CONV = 24; // twelve periods at the fastest ratio
   reg  [11:0] busy_cnt_ff;      // cycles spent with go set
   wire        ctl0_wr = reg_wr && clk_en && (reg_addr == `ADCC_OFS_CTL0);
   wire        trig_ok = special_event_trig && clk_en && (compare_unit_mode_field == `ADCC_TRIG_MODE);
   wire        ena_wr  = reg_wr && clk_en && (reg_addr == `ADCC_OFS_ENABLES);
   wire        flag_rd = reg_rd && clk_en && (reg_addr == `ADCC_OFS_FLAGS);

   // length of the running conversion, saturating
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_cnt_ff <= 12'h000;
      end else if (!conv_busy) begin
         busy_cnt_ff <= 12'h000;
      end else if (busy_cnt_ff != 12'hfff) begin
         busy_cnt_ff <= busy_cnt_ff + 12'h001;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_ABORT_NOW: assert property (conv_busy && ctl0_wr && !reg_wdata[`ADCC_GO_BIT] |=> !conv_busy)
      else $error("go stayed set after abort write");
   AST_TIMER_CLEAR: assert property (trig_ok |=> timer_count_clear)
      else $error("armed trigger did not clear timer");
   AST_CLEAR_CAUSE: assert property (timer_count_clear |-> $past(trig_ok))
      else $error("timer clear without armed trigger");
   AST_START_CAUSE: assert property ($rose(conv_busy)
      |-> $past(trig_ok || (ctl0_wr && reg_wdata[`ADCC_GO_BIT]))) else $error("conversion started without cause");
   AST_CONV_LENGTH: assert property ($fell(conv_busy) && !$past(ctl0_wr) |-> busy_cnt_ff >= MIN_CONV)
      else $error("conversion ended too early");
   AST_POST_WAIT: assert property ($fell(conv_busy) |-> !sample_en [*4])
      else $error("acquisition began inside the wait");
   AST_REACQUIRE: assert property ($fell(conv_busy) && !$past(ctl0_wr && !reg_wdata[`ADCC_ON_BIT])
      |-> ##[4:300] sample_en) else $error("acquisition did not resume");
   AST_NO_OVERLAP: assert property (!(sample_en && conv_busy))
      else $error("sampling during conversion");
   AST_DONE_IRQ: assert property ($rose(irq) |-> $fell(conv_busy) || $past(ena_wr))
      else $error("irq rose without a finish");
   AST_READ_CLEAR: assert property (flag_rd && !conv_busy && !$past(conv_busy) |=> !irq)
      else $error("flag read left irq high");

   COV_NORMAL_END: cover property ($fell(conv_busy) && !$past(ctl0_wr));
   COV_ABORT: cover property (conv_busy && ctl0_wr && !reg_wdata[`ADCC_GO_BIT]);
   COV_TRIG_START: cover property (trig_ok ##1 $rose(conv_busy));
endmodule

bind adcc_top adcc_top_monitor #(.RES_W(RES_W)) u_mon (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .compare_unit_mode_field(compare_unit_mode_field), .special_event_trig(special_event_trig),
   .rc_tick(rc_tick), .cmp_above(cmp_above), .timer_count_clear(timer_count_clear),
   .sar_trial_code(sar_trial_code), .sample_en(sample_en), .conv_busy(conv_busy),
   .channel_select(channel_select), .pin_reference_cfg(pin_reference_cfg), .irq(irq),
   .irq_high_prio(irq_high_prio));

// ===== tb/adcc_top_tb.sv
`timescale 1ns/1ps

module adcc_top_tb;
   localparam int TMO = 30000;
   localparam logic [2:0] SEL [0:6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
   localparam int RAT [0:6] = '{2, 4, 8, 16, 32, 64, 0}; // 0 marks the rc clock
   reg         core_clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         clk_en = 1'b1;
   reg  [2:0]  reg_addr = 3'h0;
   reg  [7:0]  reg_wdata = 8'h00;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   reg  [3:0]  mode_ff = 4'h0;
   reg         trig_ff = 1'b0;
   reg  [9:0]  ana_level = 10'h000;
   wire [7:0]  reg_rdata;
   wire        rc_tick, cmp_above, timer_count_clear, sample_en, conv_busy, irq, irq_high_prio;
   wire [9:0]  sar_trial_code;
   wire [3:0]  channel_select;
   wire [5:0]  pin_reference_cfg;
   wire [15:0] timer_cnt;
   integer     fails = 0, compares = 0, cyc = 0, i;
   reg  [15:0] n;
   reg  [31:0] seed = 32'd74049;
   reg  [7:0]  exp_q [$];
   reg         rd_seen = 1'b0;
   reg  [9:0]  v;
   reg  [3:0]  ch;

   adcc_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .compare_unit_mode_field(mode_ff), .special_event_trig(trig_ff), .rc_tick(rc_tick),
      .cmp_above(cmp_above), .timer_count_clear(timer_count_clear), .sar_trial_code(sar_trial_code),
      .sample_en(sample_en), .conv_busy(conv_busy), .channel_select(channel_select),
      .pin_reference_cfg(pin_reference_cfg), .irq(irq), .irq_high_prio(irq_high_prio));
   adcc_far_model u_far (.core_clk(core_clk), .sys_rst(sys_rst), .ana_level(ana_level),
      .trial_code(sar_trial_code), .timer_count_clear(timer_count_clear), .cmp_above(cmp_above),
      .rc_tick(rc_tick), .timer_cnt_ff(timer_cnt));

   always #20 core_clk = ~core_clk;

   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction

   task chk(input [15:0] seen, input [15:0] expv);
      begin
         compares = compares + 1;
         if (seen !== expv) begin
            fails = fails + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, expv);
         end
      end
   endtask

   task test_done;
      begin
         $display("compares %0d fails %0d", compares, fails);
         if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   task wr(input [2:0] a, input [7:0] dat);
      begin
         @(posedge core_clk);
         reg_addr <= a;
         reg_wdata <= dat;
         reg_wr <= 1'b1;
         @(posedge core_clk);
         reg_wr <= 1'b0;
      end
   endtask

   // expectation noted before the strobe goes out
   task rd(input [2:0] a, input [7:0] e);
      begin
         exp_q.push_back(e);
         @(posedge core_clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge core_clk);
         reg_rd <= 1'b0;
      end
   endtask

   task wait_acq;
      begin
         n = 0;
         @(negedge core_clk);
         while (sample_en !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n = n + 1;
         end
         chk(n < 400, 1'b1);
      end
   endtask

   // counts the cycles go stays set
   task conv_len;
      begin
         n = 0;
         @(posedge core_clk);
         while (conv_busy === 1'b1 && n < 2000) begin
            n = n + 1;
            @(posedge core_clk);
         end
      end
   endtask

   task trig(input [3:0] m, input eb, input ec);
      begin
         @(posedge core_clk);
         mode_ff <= m;
         trig_ff <= 1'b1;
         @(posedge core_clk);
         trig_ff <= 1'b0;
         repeat (4) @(negedge core_clk);
         chk(conv_busy, eb);
         chk(timer_cnt < 16'd8, ec);
      end
   endtask

   // read data taken one cycle after the strobe
   always @(posedge core_clk) begin
      rd_seen <= reg_rd;
      if (rd_seen)
         chk(reg_rdata, exp_q.pop_front());
   end

   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == TMO) begin
         fails = fails + 1;
         test_done;
      end
   end

   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1) rd(i[2:0], 8'h00);
      chk(irq, 1'b0);
      $display("test reset values done");
      wr(0, 8'hff);
      rd(0, 8'h00);
      for (i = 1; i < 8; i = i + 1) begin
         seed = xs(seed);
         wr(i[2:0], seed[7:0]);
         rd(i[2:0], seed[7:0] & (i < 3 ? 8'h40 : i == 5 ? 8'h3d : i == 6 ? 8'h3f : i == 7 ? 8'h87 : 8'hff));
      end
      wr(2, 8'h40);
      wr(6, 8'h2a);
      @(negedge core_clk);
      chk(irq_high_prio, 1'b1);
      chk(pin_reference_cfg, 6'h2a);
      $display("test register access done");
      wr(1, 8'h40);
      for (i = 0; i < 7; i = i + 1) begin
         seed = xs(seed);
         v = seed[9:0];
         ch = seed[13:10];
         ana_level <= v;
         wr(7, {i[0], 4'h0, SEL[i]});
         wr(5, {2'b00, ch, 2'b01});
         wait_acq;
         chk(channel_select, ch);
         wr(5, {2'b00, ch, 2'b11});
         conv_len;
         if (RAT[i] != 0) chk(n, 12 * RAT[i]);
         repeat (2) @(negedge core_clk);
         chk(irq, 1'b1);
         rd(3, i[0] ? {6'h00, v[9:8]} : v[9:2]);
         rd(4, i[0] ? v[7:0] : {v[1:0], 6'h00});
         rd(0, 8'h40);
         @(negedge core_clk);
         chk(irq, 1'b0);
      end
      $display("test conversions done");
      wr(3, 8'h5a);
      wr(4, 8'ha5);
      wait_acq;
      wr(5, 8'h03);
      repeat (10) @(posedge core_clk);
      wr(5, 8'h01);
      @(negedge core_clk);
      chk(conv_busy, 1'b0);
      chk(sample_en, 1'b0);
      rd(3, 8'h5a);
      rd(4, 8'ha5);
      rd(0, 8'h00);
      wait_acq;
      $display("test abort done");
      wr(5, 8'h00);
      wr(5, 8'h03);
      @(negedge core_clk);
      chk(conv_busy, 1'b0);
      rd(5, 8'h01);
      wr(5, 8'h00);
      trig(4'hb, 1'b0, 1'b1);
      wr(5, 8'h01);
      wait_acq;
      repeat (10) @(posedge core_clk);
      trig(4'h0, 1'b0, 1'b0);
      trig(4'ha, 1'b0, 1'b0);
      trig(4'hf, 1'b0, 1'b0);
      trig(4'hb, 1'b1, 1'b1);
      conv_len;
      rd(0, 8'h40);
      $display("test trigger done");
      repeat (3) @(posedge core_clk);
      test_done;
   end
endmodule

// ===== verilog/adcc_consts.vh
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// register offsets on the plain register port
`define ADCC_OFS_FLAGS    3'h0
`define ADCC_OFS_ENABLES  3'h1
`define ADCC_OFS_PRIOS    3'h2
`define ADCC_OFS_RES_HI   3'h3
`define ADCC_OFS_RES_LO   3'h4
`define ADCC_OFS_CTL0     3'h5
`define ADCC_OFS_CTL1     3'h6
`define ADCC_OFS_CTL2     3'h7

// field positions
`define ADCC_DONE_BIT     6
`define ADCC_ON_BIT       0
`define ADCC_GO_BIT       1
`define ADCC_CHAN_LSB     2
`define ADCC_CHAN_MSB     5
`define ADCC_CFG1_MSB     5
`define ADCC_FMT_BIT      7
`define ADCC_CSEL_MSB     2

// reset values
`define ADCC_RST_BYTE     8'h00
`define ADCC_RST_CHAN     4'h0
`define ADCC_RST_CFG1     6'h00
`define ADCC_RST_CSEL     3'h0

// compare unit mode that arms the special event trigger
`define ADCC_TRIG_MODE    4'hb

// timing counts, in conversion bit periods
`define ADCC_CONV_TADS    4'hc
`define ADCC_SAR_STEPS    4'ha
`define ADCC_WAIT_TADS    4'h2

// clock select low bits that pick the rc clock
`define ADCC_RC_SEL       2'h3

`endif

// ===== verilog/adcc_sar.v
`timescale 1ns/1ps

module adcc_sar #(
   parameter RES_W = 10
) (
   input  wire             core_clk,
   input  wire             sys_rst,
   input  wire             clk_en,
   input  wire             start,
   input  wire             step,
   input  wire             cmp_above,
   output wire [RES_W-1:0] trial_code
);

   localparam [RES_W-1:0] TOP_BIT = {1'b1, {(RES_W-1){1'b0}}};

   reg [RES_W-1:0] code_ff;   // trial and final code
   reg [RES_W-1:0] mask_ff;   // bit under decision, one hot

   assign trial_code = code_ff;

   // one decision per step, msb first; keep the bit when input is above
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         code_ff <= {RES_W{1'b0}};
         mask_ff <= {RES_W{1'b0}};
      end else if (clk_en) begin
         if (start) begin
            code_ff <= TOP_BIT;
            mask_ff <= TOP_BIT;
         end else if (step & (|mask_ff)) begin
            code_ff <= (cmp_above ? code_ff : (code_ff & ~mask_ff)) | (mask_ff >> 1);
            mask_ff <= mask_ff >> 1;
         end
      end
   end

endmodule

// ===== verilog/adcc_tad_div.v
`timescale 1ns/1ps
`include "adcc_consts.vh"

module adcc_tad_div (
   input  wire       core_clk,
   input  wire       sys_rst,
   input  wire       clk_en,
   input  wire       restart,
   input  wire [2:0] clk_sel,
   input  wire       rc_tick,
   output wire       tad_tick
);

   // terminal count for the selected ratio, ratio minus one
   function [5:0] div_limit;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    div_limit = 6'h01;
            3'h4:    div_limit = 6'h03;
            3'h1:    div_limit = 6'h07;
            3'h5:    div_limit = 6'h0f;
            3'h2:    div_limit = 6'h1f;
            3'h6:    div_limit = 6'h3f;
            default: div_limit = 6'h00;
         endcase
      end
   endfunction

   reg  [5:0] cnt_ff;       // oscillator periods inside the bit period
   reg  [5:0] nxt_cnt;
   wire       use_rc;       // rc clock picked
   wire       at_limit;

   assign use_rc   = (clk_sel[1:0] == `ADCC_RC_SEL);
   assign at_limit = (cnt_ff == div_limit(clk_sel));
   // tick not gated by restart: finish feeds restart, gating would loop
   assign tad_tick = clk_en & (use_rc ? rc_tick : at_limit);

   // divider next value
   always @* begin
      if (restart | at_limit) begin
         nxt_cnt = 6'h00;
      end else begin
         nxt_cnt = cnt_ff + 6'h01;
      end
   end

   // divider counter, frozen by clock enable
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= 6'h00;
      end else if (clk_en) begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule

// ===== verilog/adcc_top.v
// Overview of operation
// - clearing go mid conversion aborts it at once
// - abort leaves both result bytes untouched
// - abort is followed by two bit period wait
// - after the wait, acquisition restarts by itself
// - trigger starts only in mode 1011, converter on
// - accepted trigger sets go, clears timer counter
// - converter off ignores trigger, timer still cleared
// - conversion spans twelve bit periods from go
// - clock select picks ratio or rc clock
// - normal end clears go, sets done flag
`timescale 1ns/1ps
`include "adcc_consts.vh"

module adcc_top #(
   parameter RES_W = 10
) (
   input  wire             core_clk,
   input  wire             sys_rst,
   input  wire             clk_en,
   input  wire [2:0]       reg_addr,
   input  wire [7:0]       reg_wdata,
   input  wire             reg_wr,
   input  wire             reg_rd,
   output wire [7:0]       reg_rdata,
   input  wire [3:0]       compare_unit_mode_field,
   input  wire             special_event_trig,
   input  wire             rc_tick,
   input  wire             cmp_above,
   output wire             timer_count_clear,
   output wire [RES_W-1:0] sar_trial_code,
   output wire             sample_en,
   output wire             conv_busy,
   output wire [3:0]       channel_select,
   output wire [5:0]       pin_reference_cfg,
   output wire             irq,
   output wire             irq_high_prio
);

   // control sequencer states
   localparam [1:0] ST_OFF  = 2'h0;  // converter switched off
   localparam [1:0] ST_ACQ  = 2'h1;  // sampling the selected channel
   localparam [1:0] ST_CONV = 2'h2;  // conversion running
   localparam [1:0] ST_WAIT = 2'h3;  // hold off before new acquisition

   // address match, used by every write and strobe decode; the read mux cases on the address
   function reg_hit;
      input [2:0] addr;
      input [2:0] ofs;
      begin
         reg_hit = (addr == ofs);
      end
   endfunction

   // software visible state
   reg  [3:0]       channel_select_ff;     // selected input channel
   reg              go_ff;                 // conversion go flag
   reg              converter_on_ff;       // converter switched on
   reg  [5:0]       cfg1_ff;               // reference and pin config
   reg              result_format_ff;      // 1 right, 0 left justified
   reg  [2:0]       clk_select_ff;         // conversion clock select
   reg  [7:0]       result_high_byte_ff;   // result, upper register
   reg  [7:0]       result_low_byte_ff;    // result, lower register
   reg              done_flag_ff;          // sticky conversion done
   reg              done_enable_ff;        // mask for the done flag
   reg              done_priority_ff;      // priority for the done flag
   reg  [7:0]       rd_data_ff;            // read data, one cycle late

   // sequencer state
   reg  [1:0]       state_ff;
   reg  [1:0]       nxt_state;
   reg  [3:0]       tad_cnt_ff;            // bit periods in this phase
   reg  [3:0]       nxt_tad_cnt;
   reg              timer_clear_ff;        // timer reset pulse
   reg  [7:0]       nxt_rd_data;
   reg  [7:0]       nxt_res_hi;
   reg  [7:0]       nxt_res_lo;

   wire             tad_tick;              // one per bit period
   wire [RES_W-1:0] sar_code;              // successive approx code
   wire             wr_ctl0;
   wire             rd_flags;
   wire             sw_go_set;
   wire             sw_go_clr;
   wire             on_drop;
   wire             trig_mode_ok;
   wire             trig_ok;
   wire             conv_start;
   wire             conv_abort;
   wire             conv_finish;
   wire             sar_step;
   wire             wait_done;
   wire             div_restart;

   // register strobes
   assign wr_ctl0  = reg_wr & reg_hit(reg_addr, `ADCC_OFS_CTL0);
   assign rd_flags = reg_rd & reg_hit(reg_addr, `ADCC_OFS_FLAGS);

   // go only counts when the converter was already on before this write;
   // setting both in one write is ignored rather than half started
   assign sw_go_set = wr_ctl0 & reg_wdata[`ADCC_GO_BIT] & reg_wdata[`ADCC_ON_BIT]
                    & converter_on_ff & (state_ff == ST_ACQ);
   assign sw_go_clr = wr_ctl0 & ~reg_wdata[`ADCC_GO_BIT];
   assign on_drop   = wr_ctl0 & ~reg_wdata[`ADCC_ON_BIT];

   // trigger qualification
   assign trig_mode_ok = (compare_unit_mode_field == `ADCC_TRIG_MODE);
   // acquisition is assumed complete when the trigger arrives
   assign trig_ok      = special_event_trig & trig_mode_ok & converter_on_ff
                       & (state_ff == ST_ACQ);

   assign conv_start = sw_go_set | trig_ok;

   // a go clear or power down during a conversion wins over its end
   assign conv_abort  = (state_ff == ST_CONV) & (sw_go_clr | on_drop);
   assign conv_finish = (state_ff == ST_CONV) & tad_tick & ~conv_abort
                      & (tad_cnt_ff == (`ADCC_CONV_TADS - 4'h1));
   // first ten bit periods decide one result bit each
   assign sar_step    = (state_ff == ST_CONV) & tad_tick
                      & (tad_cnt_ff < `ADCC_SAR_STEPS);
   assign wait_done   = (state_ff == ST_WAIT) & tad_tick
                      & (tad_cnt_ff == (`ADCC_WAIT_TADS - 4'h1));

   // every change into or out of conversion realigns the divided bit period; the rc tick runs free
   assign div_restart = conv_start | conv_abort | conv_finish;

   // bit period generator
   adcc_tad_div u_div (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .restart  (div_restart),
      .clk_sel  (clk_select_ff),
      .rc_tick  (rc_tick),
      .tad_tick (tad_tick)
   );

   // successive approximation engine
   adcc_sar #(
      .RES_W (RES_W)
   ) u_sar (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .start      (conv_start),
      .step       (sar_step),
      .cmp_above  (cmp_above),
      .trial_code (sar_code)
   );

   // sequencer next state
   always @* begin
      nxt_state   = state_ff;
      nxt_tad_cnt = tad_cnt_ff;
      case (state_ff)
         ST_OFF: begin
            // power up goes straight to sampling
            if (converter_on_ff) begin
               nxt_state = ST_ACQ;
            end
         end
         ST_ACQ: begin
            if (~converter_on_ff) begin
               nxt_state = ST_OFF;
            end else if (conv_start) begin
               nxt_state   = ST_CONV;
               nxt_tad_cnt = 4'h0;
            end
         end
         ST_CONV: begin
            if (on_drop) begin
               nxt_state = ST_OFF;
            end else if (conv_abort | conv_finish) begin
               // same hold off after abort and after a normal end
               nxt_state   = ST_WAIT;
               nxt_tad_cnt = 4'h0;
            end else if (tad_tick) begin
               nxt_tad_cnt = tad_cnt_ff + 4'h1;
            end
         end
         ST_WAIT: begin
            if (~converter_on_ff) begin
               nxt_state = ST_OFF;
            end else if (wait_done) begin
               nxt_state = ST_ACQ;
            end else if (tad_tick) begin
               nxt_tad_cnt = tad_cnt_ff + 4'h1;
            end
         end
         default: begin
            nxt_state   = ST_OFF;
            nxt_tad_cnt = 4'h0;
         end
      endcase
   end

   // sequencer registers
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff   <= ST_OFF;
         tad_cnt_ff <= 4'h0;
      end else if (clk_en) begin
         state_ff   <= nxt_state;
         tad_cnt_ff <= nxt_tad_cnt;
      end
   end

   // timer clear on any trigger in trigger mode, on or off
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_clear_ff <= 1'b0;
      end else if (clk_en) begin
         timer_clear_ff <= special_event_trig & trig_mode_ok;
      end
   end

   // control zero: channel, go, on
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         channel_select_ff <= `ADCC_RST_CHAN;
         converter_on_ff   <= 1'b0;
         go_ff             <= 1'b0;
      end else if (clk_en) begin
         if (wr_ctl0) begin
            channel_select_ff <= reg_wdata[`ADCC_CHAN_MSB:`ADCC_CHAN_LSB];
            converter_on_ff   <= reg_wdata[`ADCC_ON_BIT];
         end
         // start sets go; finish, software clear or power down clear it
         go_ff <= conv_start | (go_ff & ~conv_finish & ~sw_go_clr & ~on_drop);
      end
   end

   // control one and two: plain configuration
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg1_ff          <= `ADCC_RST_CFG1;
         result_format_ff <= 1'b0;
         clk_select_ff    <= `ADCC_RST_CSEL;
      end else if (clk_en) begin
         if (reg_wr & reg_hit(reg_addr, `ADCC_OFS_CTL1)) begin
            cfg1_ff <= reg_wdata[`ADCC_CFG1_MSB:0];
         end
         // a select change mid conversion alters every remaining bit period
         if (reg_wr & reg_hit(reg_addr, `ADCC_OFS_CTL2)) begin
            result_format_ff <= reg_wdata[`ADCC_FMT_BIT];
            clk_select_ff    <= reg_wdata[`ADCC_CSEL_MSB:0];
         end
      end
   end

   // result bytes: finished conversion beats a software write
   always @* begin
      nxt_res_hi = result_high_byte_ff;
      nxt_res_lo = result_low_byte_ff;
      if (conv_finish) begin
         if (result_format_ff) begin
            nxt_res_hi = {6'h00, sar_code[9:8]};
            nxt_res_lo = sar_code[7:0];
         end else begin
            nxt_res_hi = sar_code[9:2];
            nxt_res_lo = {sar_code[1:0], 6'h00};
         end
      end else begin
         // an aborted conversion never reaches here with new data
         if (reg_wr & reg_hit(reg_addr, `ADCC_OFS_RES_HI)) begin
            nxt_res_hi = reg_wdata;
         end
         if (reg_wr & reg_hit(reg_addr, `ADCC_OFS_RES_LO)) begin
            nxt_res_lo = reg_wdata;
         end
      end
   end

   // result registers
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_high_byte_ff <= `ADCC_RST_BYTE;
         result_low_byte_ff  <= `ADCC_RST_BYTE;
      end else if (clk_en) begin
         result_high_byte_ff <= nxt_res_hi;
         result_low_byte_ff  <= nxt_res_lo;
      end
   end

   // done flag, mask and priority
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         done_flag_ff     <= 1'b0;
         done_enable_ff   <= 1'b0;
         done_priority_ff <= 1'b0;
      end else if (clk_en) begin
         // set wins over the clearing read in the same cycle
         done_flag_ff <= conv_finish | (done_flag_ff & ~rd_flags);
         if (reg_wr & reg_hit(reg_addr, `ADCC_OFS_ENABLES)) begin
            done_enable_ff <= reg_wdata[`ADCC_DONE_BIT];
         end
         if (reg_wr & reg_hit(reg_addr, `ADCC_OFS_PRIOS)) begin
            done_priority_ff <= reg_wdata[`ADCC_DONE_BIT];
         end
      end
   end

   // read mux; unused bits and other peripherals read as zero
   always @* begin
      nxt_rd_data = 8'h00;
      case (reg_addr)
         `ADCC_OFS_FLAGS: begin
            nxt_rd_data[`ADCC_DONE_BIT] = done_flag_ff;
         end
         `ADCC_OFS_ENABLES: begin
            nxt_rd_data[`ADCC_DONE_BIT] = done_enable_ff;
         end
         `ADCC_OFS_PRIOS: begin
            nxt_rd_data[`ADCC_DONE_BIT] = done_priority_ff;
         end
         `ADCC_OFS_RES_HI: begin
            nxt_rd_data = result_high_byte_ff;
         end
         `ADCC_OFS_RES_LO: begin
            nxt_rd_data = result_low_byte_ff;
         end
         `ADCC_OFS_CTL0: begin
            nxt_rd_data[`ADCC_CHAN_MSB:`ADCC_CHAN_LSB] = channel_select_ff;
            nxt_rd_data[`ADCC_GO_BIT]                  = go_ff;
            nxt_rd_data[`ADCC_ON_BIT]                  = converter_on_ff;
         end
         `ADCC_OFS_CTL1: begin
            nxt_rd_data[`ADCC_CFG1_MSB:0] = cfg1_ff;
         end
         `ADCC_OFS_CTL2: begin
            nxt_rd_data[`ADCC_FMT_BIT]    = result_format_ff;
            nxt_rd_data[`ADCC_CSEL_MSB:0] = clk_select_ff;
         end
         default: begin
            nxt_rd_data = 8'h00;
         end
      endcase
   end

   // read data register; holds zero outside a read's answer cycle
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data_ff <= 8'h00;
      end else if (clk_en) begin
         rd_data_ff <= reg_rd ? nxt_rd_data : 8'h00;
      end
   end

   // outputs
   assign reg_rdata         = rd_data_ff;
   assign timer_count_clear = timer_clear_ff;
   assign sar_trial_code    = sar_code;
   assign sample_en         = (state_ff == ST_ACQ);
   assign conv_busy         = go_ff;
   assign channel_select    = channel_select_ff;
   assign pin_reference_cfg = cfg1_ff;
   assign irq               = done_flag_ff & done_enable_ff;
   assign irq_high_prio     = done_priority_ff;

endmodule
